// [isr_status_map.vh]
`ifndef ISR_STATUS_MAP_VH
`define ISR_STATUS_MAP_VH

// Register byte offsets.
`define ISR_OFF_STB 8'h00
`define ISR_OFF_SRE 8'h04
`define ISR_OFF_QCOND 8'h08
`define ISR_OFF_QEVENT 8'h0C
`define ISR_OFF_QENABLE 8'h10
`define ISR_OFF_ESR 8'h14
`define ISR_OFF_ESE 8'h18
`define ISR_OFF_PSC 8'h1C
`define ISR_OFF_CMD 8'h20
`define ISR_OFF_IRQ_STAT 8'h24
`define ISR_OFF_IRQ_MASK 8'h28
`define ISR_OFF_OPER_EN 8'h2C

// Command register bits.
`define ISR_CMD_CLS 0
`define ISR_CMD_PRESET 1
`define ISR_CMD_OPC 2

// Status byte bit positions.
`define ISR_STB_ERRQ 2
`define ISR_STB_QUES_DEF 3
`define ISR_STB_MAV 4
`define ISR_STB_ESB 5
`define ISR_STB_MSS 6

// Standard event bit positions.
`define ISR_ESR_OPC 0
`define ISR_ESR_QYE 2
`define ISR_ESR_DDE 3
`define ISR_ESR_EXE 4
`define ISR_ESR_CME 5
`define ISR_ESR_PON 7

// Implemented bits of the event groups; the rest read as zero in the condition and event registers.
`define ISR_QUES_USED 16'h0321
`define ISR_ESR_USED 8'hBD

// Interrupt status bit positions.
`define ISR_IRQ_SRQ 0
`define ISR_IRQ_OPC 1
`define ISR_IRQ_QUES 2

// Reset values.
`define ISR_PSC_RST 1'h1
`define ISR_MASK8_RST 8'h00
`define ISR_MASK16_RST 16'h0000
`define ISR_IRQ_RST 3'h0

`endif

// [isr_sync.v]
`timescale 1ns/10ps
module isr_sync #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // Asynchronous levels in, filtered levels out
    input wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg out_q;
            always @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    out_q <= 1'b0;
                end else begin
                    s1_q <= i_async[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    // A change is taken only once two settled stages agree.
                    if (s2_q == s3_q) begin
                        out_q <= s3_q;
                    end
                end
            end
            assign o_sync[gi] = out_q;
        end
    endgenerate

endmodule

// [isr_event_latch.v]
`timescale 1ns/10ps
module isr_event_latch #(
    parameter WIDTH = 8,
    parameter [WIDTH-1:0] USED = {WIDTH{1'b1}}
) (
    // Clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // Set and clear requests
    input wire [WIDTH-1:0] i_set,
    input wire i_clr,
    // Latched events
    output wire [WIDTH-1:0] o_q
);

    reg [WIDTH-1:0] ev_q;
    wire [WIDTH-1:0] ev_d;

    // A set arriving with the clear survives, so no event is lost.
    assign ev_d = ((i_clr ? {WIDTH{1'b0}} : ev_q) | i_set) & USED;

    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ev_q <= {WIDTH{1'b0}};
        end else begin
            ev_q <= ev_d;
        end
    end

    assign o_q = ev_q;

endmodule

// [isr_status_top.v]
`timescale 1ns/10ps
`include "isr_status_map.vh"
module isr_status_top #(
    parameter QUES_BIT = `ISR_STB_QUES_DEF,
    parameter AW = 8
) (
    // Clock and reset
    input wire i_clk,
    input wire i_arst_n,
    // Register port
    input wire [AW-1:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [15:0] o_rdata,
    // Questionable condition levels from the instrument pins
    input wire [15:0] i_ques_cond,
    // Standard event sources, one-cycle pulses on this clock
    input wire i_query_err,
    input wire i_device_err,
    input wire i_exec_err,
    input wire i_cmd_err,
    // Command engine state, high while earlier commands are still running
    input wire i_cmds_busy,
    // Other status byte sources
    input wire i_errq_nonempty,
    input wire i_msg_avail,
    // Serial poll
    input wire i_serial_poll,
    output reg [7:0] o_poll_data,
    // Non-volatile store contents, valid from reset release
    input wire i_nv_valid,
    input wire i_nv_psc,
    input wire [7:0] i_nv_sre,
    input wire [7:0] i_nv_ese,
    // Values to keep in the non-volatile store
    output wire o_nv_psc,
    output wire [7:0] o_nv_sre,
    output wire [7:0] o_nv_ese,
    // Service request and error queue control
    output reg o_srq,
    output wire o_srq_pending,
    output reg o_errq_clear,
    // Interrupt
    output wire o_irq
);

    // Decodes one register hit; shared by the read and write paths.
    function hit;
        input [AW-1:0] addr;
        input [7:0] off;
        begin
            hit = (addr == off[AW-1:0]);
        end
    endfunction

    // Summarises one group into a single status byte bit.
    function any_set;
        input [15:0] ev;
        input [15:0] en;
        begin
            any_set = |(ev & en);
        end
    endfunction

    // Bit 6 is the summary itself and cannot be written as an enable; the power-on store load is not masked.
    localparam [7:0] SRE_WRITABLE = 8'hBF;

    reg [7:0] sre_q;
    reg [15:0] qen_q;
    reg [7:0] ese_q;
    reg [15:0] oper_en_q;
    reg psc_q;
    reg pon_q;
    reg opc_pend_q;
    reg [7:0] stb_en_prev_q;
    reg rqs_q;
    reg [2:0] irq_stat_q;
    reg [2:0] irq_mask_q;
    reg [15:0] qcond_prev_q;

    wire [15:0] qcond;
    wire [15:0] qevent;
    wire [7:0] esr;
    wire [15:0] ques_set;
    wire [7:0] esr_set;
    wire wr_cmd;
    wire cls;
    wire preset;
    wire opc_cmd;
    wire opc_done;
    wire qevent_rd;
    wire esr_rd;
    wire ques_sum;
    wire esb;
    wire mss;
    wire [7:0] stb_base;
    wire [7:0] stb;
    wire [7:0] stb_en;
    wire srq_evt;
    wire [2:0] irq_set;
    wire wr_ok;
    wire wr_sre;
    wire wr_ese;
    wire wr_psc;
    wire wr_oper;
    wire wr_qen;
    wire wr_irq_stat;
    wire wr_irq_mask;
    wire psc_boot;

    // Condition pins are asynchronous to this clock; a condition shorter than
    // about two cycles may be filtered out and never latched.
    isr_sync #(
        .WIDTH(16)
    ) u_sync (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_async(i_ques_cond),
        .o_sync(qcond)
    );

    // Writes that land on the power-on edge would race the store load, so the
    // whole write path stays shut for that one cycle.
    assign wr_ok = i_wr && !pon_q;
    assign wr_sre = wr_ok && hit(i_addr, `ISR_OFF_SRE);
    assign wr_ese = wr_ok && hit(i_addr, `ISR_OFF_ESE);
    assign wr_psc = wr_ok && hit(i_addr, `ISR_OFF_PSC);
    assign wr_oper = wr_ok && hit(i_addr, `ISR_OFF_OPER_EN);
    assign wr_qen = wr_ok && hit(i_addr, `ISR_OFF_QENABLE);
    assign wr_irq_stat = wr_ok && hit(i_addr, `ISR_OFF_IRQ_STAT);
    assign wr_irq_mask = wr_ok && hit(i_addr, `ISR_OFF_IRQ_MASK);
    assign wr_cmd = wr_ok && hit(i_addr, `ISR_OFF_CMD);
    assign cls = wr_cmd && i_wdata[`ISR_CMD_CLS];
    assign preset = wr_cmd && i_wdata[`ISR_CMD_PRESET];
    assign opc_cmd = wr_cmd && i_wdata[`ISR_CMD_OPC];
    assign qevent_rd = i_rd && hit(i_addr, `ISR_OFF_QEVENT);
    assign esr_rd = i_rd && hit(i_addr, `ISR_OFF_ESR);

    // Events latch on the rising edge of each filtered condition.
    assign ques_set = qcond & ~qcond_prev_q & `ISR_QUES_USED;

    isr_event_latch #(
        .WIDTH(16),
        .USED(`ISR_QUES_USED)
    ) u_ques_event (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_set(ques_set),
        .i_clr(qevent_rd | cls),
        .o_q(qevent)
    );

    // Completion is held back while earlier commands are still running.
    // The request is one deep; a second command while one waits merges with it.
    assign opc_done = opc_pend_q && !i_cmds_busy;

    assign esr_set = {pon_q, 1'b0, i_cmd_err, i_exec_err,
                      i_device_err, i_query_err, 1'b0, opc_done};

    isr_event_latch #(
        .WIDTH(8),
        .USED(`ISR_ESR_USED)
    ) u_std_event (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_set(esr_set),
        .i_clr(esr_rd | cls),
        .o_q(esr)
    );

    assign ques_sum = any_set(qevent, qen_q);
    assign esb = any_set({8'h00, esr}, {8'h00, ese_q});

    assign stb_base = ((8'h01 << QUES_BIT) & {8{ques_sum}})
                    | ({7'h00, i_errq_nonempty} << `ISR_STB_ERRQ)
                    | ({7'h00, i_msg_avail} << `ISR_STB_MAV)
                    | ({7'h00, esb} << `ISR_STB_ESB);

    assign stb_en = stb_base & sre_q;
    assign mss = |stb_en;
    assign stb = stb_base | ({7'h00, mss} << `ISR_STB_MSS);

    // Any enabled bit going from 0 to 1 is a new service request.
    // Writing the enable mask can raise a request too, since the enabled set changes.
    assign srq_evt = |(stb_en & ~stb_en_prev_q);
    assign o_srq_pending = rqs_q;

    assign irq_set = {(|ques_set), opc_done, srq_evt};
    assign o_irq = |(irq_stat_q & irq_mask_q);

    assign o_nv_psc = psc_q;
    assign o_nv_sre = sre_q;
    assign o_nv_ese = ese_q;

    // Setting the flag takes effect at the next power-up, not at once.
    assign psc_boot = i_nv_valid ? i_nv_psc : `ISR_PSC_RST;

    // Enable masks, power-on behaviour and command effects.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sre_q <= `ISR_MASK8_RST;
            qen_q <= `ISR_MASK16_RST;
            ese_q <= `ISR_MASK8_RST;
            oper_en_q <= `ISR_MASK16_RST;
            psc_q <= `ISR_PSC_RST;
            pon_q <= 1'b1;
        end else begin
            pon_q <= 1'b0;
            if (pon_q) begin
                // The store is caught on the first edge after release.
                psc_q <= psc_boot;
                if (!psc_boot) begin
                    sre_q <= i_nv_sre;
                    ese_q <= i_nv_ese;
                end
            end else begin
                if (wr_sre) begin
                    // The summary bit itself cannot request service.
                    sre_q <= i_wdata[7:0] & SRE_WRITABLE;
                end
                if (wr_ese) begin
                    ese_q <= i_wdata[7:0];
                end
                if (wr_psc) begin
                    psc_q <= i_wdata[0];
                end
                if (wr_oper) begin
                    oper_en_q <= i_wdata;
                end
                // Preset touches only these two masks; the status byte mask is kept.
                if (preset) begin
                    qen_q <= `ISR_MASK16_RST;
                    oper_en_q <= `ISR_MASK16_RST;
                end else if (wr_qen) begin
                    qen_q <= i_wdata;
                end
            end
        end
    end

    // Completion tracking, service request and poll state.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            opc_pend_q <= 1'b0;
            stb_en_prev_q <= 8'h00;
            rqs_q <= 1'b0;
            o_srq <= 1'b0;
            o_errq_clear <= 1'b0;
            o_poll_data <= 8'h00;
            qcond_prev_q <= 16'h0000;
        end else begin
            qcond_prev_q <= qcond;
            stb_en_prev_q <= stb_en;
            o_srq <= srq_evt;
            o_errq_clear <= cls;
            // A completion request made with a clear is cancelled with it.
            if (cls) begin
                opc_pend_q <= 1'b0;
            end else if (opc_cmd) begin
                opc_pend_q <= 1'b1;
            end else if (opc_done) begin
                opc_pend_q <= 1'b0;
            end
            // A serial poll clears the request flag; a new request still wins.
            if (srq_evt) begin
                rqs_q <= 1'b1;
            end else if (i_serial_poll || (pon_q && psc_boot)) begin
                rqs_q <= 1'b0;
            end
            if (i_serial_poll) begin
                o_poll_data <= stb;
            end
        end
    end

    // Interrupt status is write-one-to-clear; a new event wins over the clear.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            irq_stat_q <= `ISR_IRQ_RST;
            irq_mask_q <= `ISR_IRQ_RST;
        end else begin
            if (wr_irq_mask) begin
                irq_mask_q <= i_wdata[2:0];
            end
            if (wr_irq_stat) begin
                irq_stat_q <= (irq_stat_q & ~i_wdata[2:0]) | irq_set;
            end else begin
                irq_stat_q <= irq_stat_q | irq_set;
            end
        end
    end

    // Read data stand in the cycle after the strobe and only there.
    // Between reads the port returns zero, so a late sample never sees stale data.
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            if (hit(i_addr, `ISR_OFF_STB)) begin
                o_rdata <= {8'h00, stb};
            end else if (hit(i_addr, `ISR_OFF_SRE)) begin
                o_rdata <= {8'h00, sre_q};
            end else if (hit(i_addr, `ISR_OFF_QCOND)) begin
                o_rdata <= qcond & `ISR_QUES_USED;
            end else if (hit(i_addr, `ISR_OFF_QEVENT)) begin
                o_rdata <= qevent;
            end else if (hit(i_addr, `ISR_OFF_QENABLE)) begin
                o_rdata <= qen_q;
            end else if (hit(i_addr, `ISR_OFF_ESR)) begin
                o_rdata <= {8'h00, esr};
            end else if (hit(i_addr, `ISR_OFF_ESE)) begin
                o_rdata <= {8'h00, ese_q};
            end else if (hit(i_addr, `ISR_OFF_PSC)) begin
                o_rdata <= {15'h0000, psc_q};
            end else if (hit(i_addr, `ISR_OFF_CMD)) begin
                o_rdata <= {13'h0000, opc_pend_q, 2'h0};
            end else if (hit(i_addr, `ISR_OFF_IRQ_STAT)) begin
                o_rdata <= {13'h0000, irq_stat_q};
            end else if (hit(i_addr, `ISR_OFF_IRQ_MASK)) begin
                o_rdata <= {13'h0000, irq_mask_q};
            end else if (hit(i_addr, `ISR_OFF_OPER_EN)) begin
                o_rdata <= oper_en_q;
            end else begin
                o_rdata <= 16'h0000;
            end
        end else begin
            o_rdata <= 16'h0000;
        end
    end

endmodule

// [isr_host.sv]
`timescale 1ns/10ps
module isr_host #(
    parameter AW = 8
) (
    // Clock and returned read data
    input wire i_clk,
    input wire [15:0] i_rdata,
    // Register port requests
    output reg [AW-1:0] o_addr,
    output reg [15:0] o_wdata,
    output reg o_wr,
    output reg o_rd
);
    initial begin
        o_addr = '0;
        o_wdata = 16'h0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    // Masks go out as plain binary weighted words, one access per word.
    task automatic wr(input [AW-1:0] a, input [15:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        // Released data is inverted so a stale value cannot look valid.
        o_wdata <= ~d;
    endtask

    task automatic rd(input [AW-1:0] a, output [15:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask
endmodule

// [isr_status_chk.sv]
`timescale 1ns/10ps
`include "isr_status_map.vh"
module isr_status_chk #(
    parameter AW = 8
) (
    // Watched ports
    input wire i_clk,
    input wire i_arst_n,
    input wire [AW-1:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [15:0] o_rdata,
    input wire i_serial_poll,
    input wire [7:0] o_poll_data,
    input wire o_nv_psc,
    input wire [7:0] o_nv_sre,
    input wire [7:0] o_nv_ese,
    input wire o_errq_clear,
    input wire o_srq,
    input wire o_irq
);
    wire wr_cmd = i_wr && i_addr == `ISR_OFF_CMD;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data not idle");
    AST_MSS_STB: assert property ($past(i_rd && i_addr == `ISR_OFF_STB) |->
        o_rdata[6] == |(o_rdata[5:0] & $past(o_nv_sre[5:0]))) else $error("summary bit wrong");
    AST_POLL_MSS: assert property ($past(i_serial_poll) |->
        o_poll_data[6] == |(o_poll_data[5:0] & $past(o_nv_sre[5:0]))) else $error("poll bad");
    AST_ESR_ZERO: assert property ($past(i_rd && i_addr == `ISR_OFF_ESR) |->
        (o_rdata & 16'hFF42) == 16'h0000) else $error("unused event bit set");
    AST_QUES_ZERO: assert property ($past(i_rd && i_addr[7:3] == 5'h01) |->
        (o_rdata & 16'hFCDE) == 16'h0000) else $error("unused questionable bit set");
    AST_SRE_WR: assert property ($past(i_arst_n) && i_wr && i_addr == `ISR_OFF_SRE |=>
        o_nv_sre == {$past(i_wdata[7]), 1'b0, $past(i_wdata[5:0])}) else $error("sre bad");
    AST_ESE_WR: assert property ($past(i_arst_n) && i_wr && i_addr == `ISR_OFF_ESE |=>
        o_nv_ese == $past(i_wdata[7:0])) else $error("ese bad");
    AST_PSC_WR: assert property ($past(i_arst_n) && i_wr && i_addr == `ISR_OFF_PSC |=>
        o_nv_psc == $past(i_wdata[0])) else $error("psc bad");
    AST_MASK_KEEP: assert property ($past(i_arst_n) && wr_cmd && i_wdata[1:0] != 2'h0 |=>
        $stable(o_nv_sre) && $stable(o_nv_ese)) else $error("mask changed");
    AST_ERRQ_CLR: assert property ($past(i_arst_n) && wr_cmd && i_wdata[0] |=>
        o_errq_clear) else $error("error queue not cleared");
    AST_ERRQ_CAUSE: assert property (o_errq_clear |-> $past(wr_cmd && i_wdata[0]))
        else $error("stray queue clear");

    COV_SRQ: cover property (o_srq);
    COV_CLS: cover property (o_errq_clear);
    COV_IRQ: cover property (o_irq);
endmodule

bind isr_status_top isr_status_chk #(.AW(AW)) u_chk (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_serial_poll(i_serial_poll),
    .o_poll_data(o_poll_data), .o_nv_psc(o_nv_psc), .o_nv_sre(o_nv_sre),
    .o_nv_ese(o_nv_ese), .o_errq_clear(o_errq_clear), .o_srq(o_srq), .o_irq(o_irq)
);

// [isr_status_top_bench.sv]
`timescale 1ns/10ps
`include "isr_status_map.vh"
module isr_status_top_bench;
    reg i_clk, i_arst_n, i_cmds_busy, i_serial_poll, i_nv_valid, i_nv_psc;
    reg i_errq_nonempty, i_msg_avail;
    reg [15:0] i_ques_cond;
    reg [3:0] ev;
    reg [7:0] i_nv_sre, i_nv_ese;
    wire [7:0] i_addr, o_poll_data;
    wire [15:0] i_wdata, o_rdata;
    wire i_wr, i_rd, o_srq, o_srq_pending, o_irq;
    integer err_total = 0;
    integer tests_run = 0;
    integer srq_n = 0;

    isr_status_top dut (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ques_cond(i_ques_cond),
        .i_query_err(ev[0]), .i_device_err(ev[1]), .i_exec_err(ev[2]), .i_cmd_err(ev[3]),
        .i_cmds_busy(i_cmds_busy), .i_errq_nonempty(i_errq_nonempty),
        .i_msg_avail(i_msg_avail),
        .i_serial_poll(i_serial_poll), .o_poll_data(o_poll_data), .i_nv_valid(i_nv_valid),
        .i_nv_psc(i_nv_psc), .i_nv_sre(i_nv_sre), .i_nv_ese(i_nv_ese), .o_nv_psc(),
        .o_nv_sre(), .o_nv_ese(), .o_srq(o_srq), .o_srq_pending(o_srq_pending),
        .o_errq_clear(), .o_irq(o_irq)
    );
    isr_host host (
        .i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
        .o_wr(i_wr), .o_rd(i_rd)
    );

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        if (o_srq === 1'b1) srq_n <= srq_n + 1;
    end

    task chk(input [15:0] got, input [15:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task rchk(input [7:0] a, input [15:0] exp);
        reg [15:0] d;
        begin
            host.rd(a, d);
            chk(d, exp);
        end
    endtask
    task pwr;
        begin
            i_arst_n <= 1'b0;
            repeat (16) @(posedge i_clk);
            i_arst_n <= 1'b1;
            @(posedge i_clk);
        end
    endtask
    task evp;
        begin
            @(posedge i_clk);
            ev <= 4'hF;
            @(posedge i_clk);
            ev <= 4'h0;
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", tests_run, err_total);
            if (err_total == 0 && tests_run > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask

    // About 200 cycles of tests; the limit leaves a wide margin.
    initial begin
        #400000;
        err_total = err_total + 1;
        print_verdict;
    end

    initial begin
        {i_arst_n, i_cmds_busy, i_serial_poll, i_nv_valid, i_nv_psc} = 5'h00;
        {i_errq_nonempty, i_msg_avail} = 2'h0;
        {i_ques_cond, ev, i_nv_sre, i_nv_ese} = 36'h0;
        pwr;
        rchk(`ISR_OFF_PSC, 16'h0001);
        rchk(`ISR_OFF_ESR, 16'h0080);
        rchk(`ISR_OFF_ESR, 16'h0000);
        rchk(8'h40, 16'h0000);
        $display("test power-up done");
        evp;
        host.wr(`ISR_OFF_ESE, 16'h003C);
        rchk(`ISR_OFF_ESE, 16'h003C);
        rchk(`ISR_OFF_STB, 16'h0020);
        host.wr(`ISR_OFF_SRE, 16'h0060);
        rchk(`ISR_OFF_SRE, 16'h0020);
        rchk(`ISR_OFF_STB, 16'h0060);
        rchk(`ISR_OFF_STB, 16'h0060);
        chk(srq_n[15:0], 16'h0001);
        i_serial_poll <= 1'b1;
        @(posedge i_clk);
        i_serial_poll <= 1'b0;
        @(posedge i_clk);
        #1;
        chk({8'h00, o_poll_data}, 16'h0060);
        chk({15'h0000, o_srq_pending}, 16'h0000);
        chk({15'h0000, o_irq}, 16'h0000);
        host.wr(`ISR_OFF_IRQ_MASK, 16'h0007);
        #1 chk({15'h0000, o_irq}, 16'h0001);
        host.wr(`ISR_OFF_IRQ_STAT, 16'h0001);
        #1 chk({15'h0000, o_irq}, 16'h0000);
        rchk(`ISR_OFF_ESR, 16'h003C);
        rchk(`ISR_OFF_STB, 16'h0000);
        {i_errq_nonempty, i_msg_avail} <= 2'h3;
        host.wr(`ISR_OFF_SRE, 16'h0004);
        rchk(`ISR_OFF_STB, 16'h0054);
        host.wr(`ISR_OFF_SRE, 16'h0020);
        {i_errq_nonempty, i_msg_avail} <= 2'h0;
        rchk(`ISR_OFF_STB, 16'h0000);
        $display("test service request done");
        i_ques_cond <= 16'hFFFF;
        repeat (8) @(posedge i_clk);
        rchk(`ISR_OFF_QCOND, 16'h0321);
        rchk(`ISR_OFF_QCOND, 16'h0321);
        rchk(`ISR_OFF_QEVENT, 16'h0321);
        rchk(`ISR_OFF_QEVENT, 16'h0000);
        host.wr(`ISR_OFF_QENABLE, 16'h0020);
        i_ques_cond <= 16'h0000;
        repeat (8) @(posedge i_clk);
        i_ques_cond <= 16'h0020;
        repeat (8) @(posedge i_clk);
        rchk(`ISR_OFF_STB, 16'h0008);
        evp;
        host.wr(`ISR_OFF_CMD, 16'h0001);
        rchk(`ISR_OFF_QEVENT, 16'h0000);
        rchk(`ISR_OFF_STB, 16'h0000);
        rchk(`ISR_OFF_QENABLE, 16'h0020);
        rchk(`ISR_OFF_ESE, 16'h003C);
        $display("test questionable done");
        i_cmds_busy <= 1'b1;
        host.wr(`ISR_OFF_CMD, 16'h0004);
        rchk(`ISR_OFF_CMD, 16'h0004);
        rchk(`ISR_OFF_ESR, 16'h0000);
        i_cmds_busy <= 1'b0;
        repeat (3) @(posedge i_clk);
        rchk(`ISR_OFF_ESR, 16'h0001);
        rchk(`ISR_OFF_IRQ_STAT, 16'h0007);
        i_cmds_busy <= 1'b1;
        host.wr(`ISR_OFF_CMD, 16'h0004);
        host.wr(`ISR_OFF_CMD, 16'h0001);
        i_cmds_busy <= 1'b0;
        repeat (3) @(posedge i_clk);
        rchk(`ISR_OFF_ESR, 16'h0000);
        $display("test completion done");
        host.wr(`ISR_OFF_OPER_EN, 16'hFFFF);
        host.wr(`ISR_OFF_CMD, 16'h0002);
        rchk(`ISR_OFF_OPER_EN, 16'h0000);
        rchk(`ISR_OFF_QENABLE, 16'h0000);
        rchk(`ISR_OFF_SRE, 16'h0020);
        host.wr(`ISR_OFF_PSC, 16'h0000);
        rchk(`ISR_OFF_PSC, 16'h0000);
        {i_nv_valid, i_nv_psc, i_nv_sre, i_nv_ese} <= 18'h2203C;
        pwr;
        rchk(`ISR_OFF_SRE, 16'h0020);
        rchk(`ISR_OFF_ESE, 16'h003C);
        i_nv_psc <= 1'b1;
        pwr;
        rchk(`ISR_OFF_ESE, 16'h0000);
        rchk(`ISR_OFF_PSC, 16'h0001);
        $display("test preset and power cycle done");
        print_verdict;
    end
endmodule
